// File: include/acbw_pkg.sv
/*
 * Constants for the actuator configuration and bus watchdog register slice:
 * register addresses, field codes, reset values, limits and timing.
 * Assumes a Modbus frame handler outside that turns register reads and writes
 * into single-cycle strobes on the 0-based register address.
 */
package acbw_pkg;

    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned SECOND_NS     = 1000000000;

    // 0-based register addresses, as used on the wire
    localparam logic [15:0] ADDR_MALFUNCTION = 16'h0068;
    localparam logic [15:0] ADDR_SENSOR_ONE  = 16'h006B;
    localparam logic [15:0] ADDR_FAIL_POS    = 16'h006C;
    localparam logic [15:0] ADDR_WD_TIMEOUT  = 16'h006D;
    localparam logic [15:0] ADDR_NOM_M3H     = 16'h006E;
    localparam logic [15:0] ADDR_RSVD_A      = 16'h006F;
    localparam logic [15:0] ADDR_NOM_LOW     = 16'h0070;
    localparam logic [15:0] ADDR_NOM_HIGH    = 16'h0071;
    localparam logic [15:0] ADDR_RSVD_B      = 16'h0072;
    localparam logic [15:0] ADDR_RSVD_C      = 16'h0073;
    localparam logic [15:0] ADDR_CTRL_MODE   = 16'h0074;
    localparam logic [15:0] ADDR_FLOW_UNIT   = 16'h0075;
    localparam logic [15:0] ADDR_SP_SOURCE   = 16'h0076;

    localparam logic [15:0] WORD_UNSUPPORTED = 16'hFFFF;
    localparam int unsigned MALF_WDOG_BIT    = 10;

    localparam logic [2:0]  SENS_NONE   = 3'h0;
    localparam logic [2:0]  SENS_ACTIVE = 3'h1;
    localparam logic [2:0]  SENS_SWITCH = 3'h4;

    localparam logic [1:0]  FAIL_NONE  = 2'h0;
    localparam logic [1:0]  FAIL_CLOSE = 2'h1;
    localparam logic [1:0]  FAIL_OPEN  = 2'h2;
    localparam logic [1:0]  FAIL_MID   = 2'h3;

    localparam logic [11:0] TIMEOUT_RESET = 12'h000;
    localparam logic [11:0] TIMEOUT_MAX   = 12'hE10;
    localparam logic [11:0] TIMEOUT_AUTO  = 12'h078;

    localparam logic        MODE_POSITION = 1'b0;
    localparam logic        MODE_FLOW     = 1'b1;

    localparam logic [2:0]  UNIT_M3S   = 3'h0;
    localparam logic [2:0]  UNIT_M3H   = 3'h1;
    localparam logic [2:0]  UNIT_LS    = 3'h2;
    localparam logic [2:0]  UNIT_LMIN  = 3'h3;
    localparam logic [2:0]  UNIT_LH    = 3'h4;
    localparam logic [2:0]  UNIT_GPM   = 3'h5;
    localparam logic [2:0]  UNIT_CFM   = 3'h6;

    localparam logic        SRC_ANALOG = 1'b0;
    localparam logic        SRC_BUS    = 1'b1;

    // Thousandths of the unit per m3/h, in Q16 fixed point
    localparam logic [39:0] K_M3S  = 40'h00_0000_471C;
    localparam logic [39:0] K_M3H  = 40'h00_03E8_0000;
    localparam logic [39:0] K_LS   = 40'h00_0115_C71C;
    localparam logic [39:0] K_LMIN = 40'h00_411A_AAAB;
    localparam logic [39:0] K_LH   = 40'h0F_4240_0000;
    localparam logic [39:0] K_GPM  = 40'h00_1132_CB35;
    localparam logic [39:0] K_CFM  = 40'h00_024C_90F8;

endpackage

// File: logic/acbw_config.sv
/*
 * Configuration register slice of a bus-controlled airflow actuator:
 * sensor type, bus watchdog, nominal flow readback and mode selectors.
 * Assumes a Modbus frame handler on the same clock that presents one
 * register access per strobe at a 0-based address, and control logic that
 * strobes setpoint_write_i / override_write_i on writes to registers 1 and 2.
 */
// Functional notes
// - Sensor one type: 0 none, 1 active/hybrid, 4 switch; 2,3 unused; resets 0.
// - Analog source with active sensor makes the analog setpoint report in millivolts.
// - Supervision off by default; without it the last setpoint is simply kept.
// - With supervision on, no setpoint/override rewrite before timeout drives fail position.
// - A watchdog trip is recorded in the malfunction register for the master.
// - Trip is bit 10 of the malfunction word; other fault bits may coexist.
// - Fail position offers none, fast close, fast open, mid; resets to none.
// - Timeout in whole seconds 0..3600; zero disables supervision entirely.
// - Timeout defaults 0, but becomes 120 s when a fail position other than none is chosen before any timeout write.
// - Nominal flow 32-bit in thousandths: low word at 112, high at 113.
// - The 32-bit nominal flow always follows the chosen flow unit.
// - Control mode 0 selects position control, 1 selects flow control.
// - Flow unit: 0 m3/s,1 m3/h,2 l/s,3 l/min,4 l/h,5 gpm,6 cfm; resets 1.
// - Setpoint source 0 analog input, 1 bus register; resets to 1.
`timescale 1ns/10ps
module acbw_config #(
    parameter int unsigned CYCLES_PER_SEC = acbw_pkg::SECOND_NS / acbw_pkg::CLK_PERIOD_NS
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [15:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    output logic             reg_wack_o,
    output logic             reg_werr_o,
    input  wire logic        setpoint_write_i,
    input  wire logic        override_write_i,
    input  wire logic [15:0] fault_bits_i,
    input  wire logic [15:0] nominal_m3h_i,
    output logic      [2:0]  sensor_one_type_o,
    output logic             analog_mv_report_o,
    output logic             control_mode_o,
    output logic      [2:0]  chosen_flow_unit_o,
    output logic             setpoint_source_o,
    output logic             watchdog_trip_o,
    output logic             fail_active_o,
    output logic      [1:0]  fail_position_o
);
    typedef struct packed {
        logic [2:0]  sensor;
        logic [1:0]  fail;
        logic [11:0] timeout;
        logic        timeout_set;
        logic        mode;
        logic [2:0]  unit;
        logic        src;
        logic [15:0] rdata;
        logic        rvalid;
        logic        wack;
        logic        werr;
        logic        analog_mv;
        logic        trip;
        logic        fail_active;
        logic [1:0]  fail_pos;
    } acbw_cfg_state_t;

    acbw_cfg_state_t s;
    acbw_cfg_state_t next_s;
    logic            wd_trip;
    logic [31:0]     flow_value;
    logic [15:0]     malfunction;

    // Refusing illegal codes keeps every field inside its documented range
    function automatic logic acbw_write_legal(input logic [15:0] addr,
                                              input logic [15:0] data);
        case (addr)
            acbw_pkg::ADDR_SENSOR_ONE:
                acbw_write_legal = (data == 16'(acbw_pkg::SENS_NONE))
                                || (data == 16'(acbw_pkg::SENS_ACTIVE))
                                || (data == 16'(acbw_pkg::SENS_SWITCH));
            acbw_pkg::ADDR_FAIL_POS:
                acbw_write_legal = (data <= 16'(acbw_pkg::FAIL_MID));
            acbw_pkg::ADDR_WD_TIMEOUT:
                acbw_write_legal = (data <= 16'(acbw_pkg::TIMEOUT_MAX));
            acbw_pkg::ADDR_CTRL_MODE:
                acbw_write_legal = (data <= 16'(acbw_pkg::MODE_FLOW));
            acbw_pkg::ADDR_FLOW_UNIT:
                acbw_write_legal = (data <= 16'(acbw_pkg::UNIT_CFM));
            acbw_pkg::ADDR_SP_SOURCE:
                acbw_write_legal = (data <= 16'(acbw_pkg::SRC_BUS));
            default:
                acbw_write_legal = 1'b0;
        endcase
    endfunction

    function automatic logic acbw_is_unsupported(input logic [15:0] addr);
        acbw_is_unsupported = (addr == acbw_pkg::ADDR_RSVD_A)
                           || (addr == acbw_pkg::ADDR_RSVD_B)
                           || (addr == acbw_pkg::ADDR_RSVD_C);
    endfunction

    acbw_watchdog #(
        .CYCLES_PER_SEC (CYCLES_PER_SEC)
    ) u_watchdog (
        .clk_i          (clk_i),
        .resetn_i       (resetn_i),
        .timeout_s_i    (s.timeout),
        .renew_i        (setpoint_write_i | override_write_i),
        .trip_o         (wd_trip)
    );

    acbw_flow_scale u_flow_scale (
        .clk_i              (clk_i),
        .resetn_i           (resetn_i),
        .nominal_m3h_i      (nominal_m3h_i),
        .chosen_flow_unit_i (s.unit),
        .flow_value_o       (flow_value)
    );

    // Outside fault bits pass through; only the watchdog bit is owned here
    always_comb
    begin
        malfunction = fault_bits_i;
        malfunction[acbw_pkg::MALF_WDOG_BIT] = wd_trip;
    end

    always_comb
    begin
        next_s        = s;
        next_s.rvalid = 1'b0;
        next_s.wack   = 1'b0;
        next_s.werr   = 1'b0;

        if (reg_wr_i)
        begin
            if (acbw_write_legal(reg_addr_i, reg_wdata_i))
            begin
                next_s.wack = 1'b1;
                case (reg_addr_i)
                    acbw_pkg::ADDR_SENSOR_ONE:
                        next_s.sensor = reg_wdata_i[2:0];
                    acbw_pkg::ADDR_FAIL_POS:
                    begin
                        next_s.fail = reg_wdata_i[1:0];
                        // Only an untouched timeout takes the automatic value
                        if (reg_wdata_i[1:0] != acbw_pkg::FAIL_NONE && !s.timeout_set)
                            next_s.timeout = acbw_pkg::TIMEOUT_AUTO;
                    end
                    acbw_pkg::ADDR_WD_TIMEOUT:
                    begin
                        next_s.timeout     = reg_wdata_i[11:0];
                        next_s.timeout_set = 1'b1;
                    end
                    acbw_pkg::ADDR_CTRL_MODE:
                        next_s.mode = reg_wdata_i[0];
                    acbw_pkg::ADDR_FLOW_UNIT:
                        next_s.unit = reg_wdata_i[2:0];
                    acbw_pkg::ADDR_SP_SOURCE:
                        next_s.src = reg_wdata_i[0];
                    default: ;
                endcase
            end
            else
                next_s.werr = 1'b1;
        end

        if (reg_rd_i)
        begin
            next_s.rvalid = 1'b1;
            case (reg_addr_i)
                acbw_pkg::ADDR_MALFUNCTION: next_s.rdata = malfunction;
                acbw_pkg::ADDR_SENSOR_ONE:  next_s.rdata = 16'(s.sensor);
                acbw_pkg::ADDR_FAIL_POS:    next_s.rdata = 16'(s.fail);
                acbw_pkg::ADDR_WD_TIMEOUT:  next_s.rdata = 16'(s.timeout);
                acbw_pkg::ADDR_NOM_M3H:     next_s.rdata = nominal_m3h_i;
                acbw_pkg::ADDR_NOM_LOW:     next_s.rdata = flow_value[15:0];
                acbw_pkg::ADDR_NOM_HIGH:    next_s.rdata = flow_value[31:16];
                acbw_pkg::ADDR_CTRL_MODE:   next_s.rdata = 16'(s.mode);
                acbw_pkg::ADDR_FLOW_UNIT:   next_s.rdata = 16'(s.unit);
                acbw_pkg::ADDR_SP_SOURCE:   next_s.rdata = 16'(s.src);
                default:                    next_s.rdata = acbw_pkg::WORD_UNSUPPORTED;
            endcase
        end

        next_s.analog_mv = (s.src == acbw_pkg::SRC_ANALOG)
                        && (s.sensor == acbw_pkg::SENS_ACTIVE);
        next_s.trip = wd_trip;
        // Fail none keeps the last setpoint even when the trip is reported
        next_s.fail_active = wd_trip && (s.fail != acbw_pkg::FAIL_NONE);
        next_s.fail_pos    = s.fail;
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            s             <= '0;
            s.sensor      <= acbw_pkg::SENS_NONE;
            s.fail        <= acbw_pkg::FAIL_NONE;
            s.timeout     <= acbw_pkg::TIMEOUT_RESET;
            s.mode        <= acbw_pkg::MODE_POSITION;
            s.unit        <= acbw_pkg::UNIT_M3H;
            s.src         <= acbw_pkg::SRC_BUS;
            s.fail_pos    <= acbw_pkg::FAIL_NONE;
        end
        else
            s <= next_s;
    end

    assign reg_rdata_o        = s.rdata;
    assign reg_rvalid_o       = s.rvalid;
    assign reg_wack_o         = s.wack;
    assign reg_werr_o         = s.werr;
    assign sensor_one_type_o  = s.sensor;
    assign analog_mv_report_o = s.analog_mv;
    assign control_mode_o     = s.mode;
    assign chosen_flow_unit_o = s.unit;
    assign setpoint_source_o  = s.src;
    assign watchdog_trip_o    = s.trip;
    assign fail_active_o      = s.fail_active;
    assign fail_position_o    = s.fail_pos;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_sensor_code_legal: assert property (
        sensor_one_type_o == acbw_pkg::SENS_NONE || sensor_one_type_o == acbw_pkg::SENS_ACTIVE
        || sensor_one_type_o == acbw_pkg::SENS_SWITCH)
        else $error("sensor type holds an unused code");

    a_analog_mv_report: assert property (
        (s.src == acbw_pkg::SRC_ANALOG && s.sensor == acbw_pkg::SENS_ACTIVE)
        ##1 (s.src == acbw_pkg::SRC_ANALOG && s.sensor == acbw_pkg::SENS_ACTIVE)
        |-> analog_mv_report_o)
        else $error("millivolt report missing for analog source with active sensor");

    a_no_supervision: assert property (
        (s.timeout == '0) [*3] |-> !fail_active_o && !watchdog_trip_o)
        else $error("fail position taken with supervision off");

    a_fail_drive: assert property (
        (wd_trip && s.fail != acbw_pkg::FAIL_NONE)
        |=> fail_active_o && fail_position_o == $past(s.fail))
        else $error("watchdog trip did not drive the fail position");

    a_malf_trip_bit: assert property (
        (reg_rd_i && reg_addr_i == acbw_pkg::ADDR_MALFUNCTION)
        |=> reg_rvalid_o && reg_rdata_o[acbw_pkg::MALF_WDOG_BIT] == $past(wd_trip))
        else $error("malfunction word does not show the watchdog trip");

    a_timeout_range: assert property (
        s.timeout <= acbw_pkg::TIMEOUT_MAX)
        else $error("watchdog timeout above its limit");

    a_auto_timeout: assert property (
        (reg_wr_i && reg_addr_i == acbw_pkg::ADDR_FAIL_POS && reg_wdata_i != 16'h0000
         && reg_wdata_i <= 16'(acbw_pkg::FAIL_MID) && !s.timeout_set)
        |=> s.timeout == acbw_pkg::TIMEOUT_AUTO && reg_wack_o)
        else $error("fail position did not bring the 120 s timeout");

    a_flow_low_word: assert property (
        (reg_rd_i && reg_addr_i == acbw_pkg::ADDR_NOM_LOW)
        |=> reg_rdata_o == $past(flow_value[15:0]))
        else $error("nominal flow low word mismatch");

    a_mode_refused: assert property (
        (reg_wr_i && reg_addr_i == acbw_pkg::ADDR_CTRL_MODE && reg_wdata_i > 16'h0001)
        |=> reg_werr_o && $stable(control_mode_o))
        else $error("illegal control mode accepted");

    a_unit_refused: assert property (
        (reg_wr_i && reg_addr_i == acbw_pkg::ADDR_FLOW_UNIT && reg_wdata_i > 16'h0006)
        |=> reg_werr_o && $stable(chosen_flow_unit_o))
        else $error("illegal flow unit accepted");

    a_unsupported_read: assert property (
        (reg_rd_i && acbw_is_unsupported(reg_addr_i))
        |=> reg_rvalid_o && reg_rdata_o == acbw_pkg::WORD_UNSUPPORTED)
        else $error("unsupported address did not read all ones");

    a_fail_refused: assert property (
        (reg_wr_i && reg_addr_i == acbw_pkg::ADDR_FAIL_POS
         && reg_wdata_i > 16'(acbw_pkg::FAIL_MID))
        |=> reg_werr_o && $stable(s.fail))
        else $error("illegal fail position accepted");

    a_source_store: assert property (
        (reg_wr_i && reg_addr_i == acbw_pkg::ADDR_SP_SOURCE
         && reg_wdata_i <= 16'(acbw_pkg::SRC_BUS))
        |=> reg_wack_o && setpoint_source_o == $past(reg_wdata_i[0]))
        else $error("setpoint source write not stored");

endmodule // acbw_config

// File: logic/acbw_flow_scale.sv
/*
 * Converts the nominal flow in whole m3/h into a 32-bit value in
 * thousandths of the chosen unit. Result is registered, one cycle late.
 * Assumes nominal flow and unit come from logic on the same clock.
 */
`timescale 1ns/10ps
module acbw_flow_scale (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [15:0] nominal_m3h_i,
    input  wire logic [2:0]  chosen_flow_unit_i,
    output logic      [31:0] flow_value_o
);
    typedef struct packed {
        logic [31:0] value;
    } acbw_scale_state_t;

    acbw_scale_state_t s;
    acbw_scale_state_t next_s;
    logic [55:0]       product;

    function automatic logic [39:0] acbw_unit_factor(input logic [2:0] unit);
        case (unit)
            acbw_pkg::UNIT_M3S:  acbw_unit_factor = acbw_pkg::K_M3S;
            acbw_pkg::UNIT_M3H:  acbw_unit_factor = acbw_pkg::K_M3H;
            acbw_pkg::UNIT_LS:   acbw_unit_factor = acbw_pkg::K_LS;
            acbw_pkg::UNIT_LMIN: acbw_unit_factor = acbw_pkg::K_LMIN;
            acbw_pkg::UNIT_LH:   acbw_unit_factor = acbw_pkg::K_LH;
            acbw_pkg::UNIT_GPM:  acbw_unit_factor = acbw_pkg::K_GPM;
            acbw_pkg::UNIT_CFM:  acbw_unit_factor = acbw_pkg::K_CFM;
            default:             acbw_unit_factor = acbw_pkg::K_M3H;
        endcase
    endfunction

    always_comb
    begin
        next_s = s;
        // Truncation toward zero; for l/h, nominal flows above 4294 m3/h overflow the 32 bits and wrap
        product = 56'(nominal_m3h_i) * 56'(acbw_unit_factor(chosen_flow_unit_i));
        next_s.value = product[47:16];
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign flow_value_o = s.value;

endmodule // acbw_flow_scale

// File: logic/acbw_watchdog.sv
/*
 * Bus watchdog: counts whole seconds since the last renewal and trips when
 * the programmed timeout is reached. A timeout of zero switches it off.
 * Assumes renew_i is a one-cycle strobe on the same clock.
 */
`timescale 1ns/10ps
module acbw_watchdog #(
    parameter int unsigned CYCLES_PER_SEC = acbw_pkg::SECOND_NS / acbw_pkg::CLK_PERIOD_NS
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [11:0] timeout_s_i,
    input  wire logic        renew_i,
    output logic             trip_o
);
    typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_TRIP} acbw_wd_mode_t;

    typedef struct packed {
        acbw_wd_mode_t mode;
        logic [31:0]   pre;
        logic [11:0]   secs;
        logic          trip;
    } acbw_wd_state_t;

    localparam logic [31:0] PRE_LAST = 32'(CYCLES_PER_SEC - 1);

    acbw_wd_state_t s;
    acbw_wd_state_t next_s;

    always_comb
    begin
        next_s = s;
        case (s.mode)
            WD_OFF:
            begin
                next_s.pre  = '0;
                next_s.secs = '0;
                if (timeout_s_i != '0)
                    next_s.mode = WD_RUN;
            end
            WD_RUN:
            begin
                if (timeout_s_i == '0)
                    next_s.mode = WD_OFF;
                else if (s.secs >= timeout_s_i)
                    next_s.mode = WD_TRIP; // Expiry wins over a renewal in the same cycle
                else if (renew_i)
                begin
                    next_s.pre  = '0;
                    next_s.secs = '0;
                end
                else if (s.pre == PRE_LAST)
                begin
                    next_s.pre  = '0;
                    next_s.secs = s.secs + 12'h001;
                end
                else
                    next_s.pre = s.pre + 32'h0000_0001;
            end
            WD_TRIP:
            begin
                if (timeout_s_i == '0)
                    next_s.mode = WD_OFF;
                else if (renew_i)
                begin
                    next_s.mode = WD_RUN;
                    next_s.pre  = '0;
                    next_s.secs = '0;
                end
            end
            default: next_s.mode = WD_OFF;
        endcase
        next_s.trip = (next_s.mode == WD_TRIP);
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            s <= '{mode: WD_OFF, pre: '0, secs: '0, trip: 1'b0};
        else
            s <= next_s;
    end

    assign trip_o = s.trip;

    a_off_no_trip: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (timeout_s_i == '0) |=> !trip_o)
        else $error("watchdog tripped while switched off");

endmodule // acbw_watchdog

// File: test/acbw_master.sv
/* Bus master stand-in: one register access per strobe, one cycle long.
   Waits up to four cycles after the taken edge for the slice to answer. */
`timescale 1ns/10ps
module acbw_master (
    input  wire logic        clk_i,
    output logic      [15:0] addr_o,
    output logic             wr_o,
    output logic      [15:0] wdata_o,
    output logic             rd_o,
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i,
    input  wire logic        wack_i,
    input  wire logic        werr_i
);
    initial
    begin
        addr_o  = 16'h0000;
        wr_o    = 1'b0;
        wdata_o = 16'h0000;
        rd_o    = 1'b0;
    end

    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic err);
        q   = 16'hXXXX;
        err = 1'b1;
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= w;
        rd_o    <= ~w;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        rd_o    <= 1'b0;
        // Released lines show the inverse, so a stale value cannot pass
        addr_o  <= ~a;
        wdata_o <= ~d;
        for (int n = 0; n < 4; n++)
        begin
            @(posedge clk_i);
            if (rvalid_i === 1'b1 || wack_i === 1'b1)
            begin
                q   = rdata_i;
                err = 1'b0;
                break;
            end
            if (werr_i === 1'b1)
                break;
        end
    endtask
endmodule // acbw_master

// File: test/tb_actuator_config_bus_watchdog.sv
/* Self-checking bench for the configuration slice and its bus watchdog.
   Assumes a shortened second of 4 clock cycles. */
`timescale 1ns/10ps
module tb_actuator_config_bus_watchdog;
    logic clk_i = 1'b0, resetn_i = 1'b0, sp = 1'b0, ov = 1'b0;
    logic [15:0] addr, wdata, rdata, faults = 16'h0006, nom = 16'h0064;
    logic wr, rd, rvalid, wack, werr, amv, mode, src, trip, fact;
    logic [2:0] sensor, unit;
    logic [1:0] fpos;
    int n_errors = 0, total_checks = 0;

    always #2.5 clk_i = ~clk_i;

    acbw_master master (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd),
        .rdata_i(rdata), .rvalid_i(rvalid), .wack_i(wack), .werr_i(werr));
    acbw_config #(.CYCLES_PER_SEC(4)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_wack_o(wack), .reg_werr_o(werr),
        .setpoint_write_i(sp), .override_write_i(ov), .fault_bits_i(faults),
        .nominal_m3h_i(nom), .sensor_one_type_o(sensor), .analog_mv_report_o(amv),
        .control_mode_o(mode), .chosen_flow_unit_o(unit), .setpoint_source_o(src),
        .watchdog_trip_o(trip), .fail_active_o(fact), .fail_position_o(fpos));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d, input logic e);
        logic [15:0] q;
        logic err;
        master.access(1'b1, a, d, q, err);
        check({31'h00000000, err}, {31'h00000000, e});
    endtask
    task automatic rd_reg(input logic [15:0] a, input logic [15:0] x);
        logic [15:0] q;
        logic err;
        master.access(1'b0, a, 16'h0000, q, err);
        check({16'h0000, q}, {16'h0000, x});
    endtask
    task automatic pulse(input logic o);
        @(posedge clk_i);
        sp <= ~o;
        ov <= o;
        @(posedge clk_i);
        sp <= 1'b0;
        ov <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic t_reset();
        rd_reg(acbw_pkg::ADDR_SENSOR_ONE, 16'h0000);
        rd_reg(acbw_pkg::ADDR_FAIL_POS, 16'h0000);
        rd_reg(acbw_pkg::ADDR_WD_TIMEOUT, 16'h0000);
        rd_reg(acbw_pkg::ADDR_CTRL_MODE, 16'h0000);
        rd_reg(acbw_pkg::ADDR_FLOW_UNIT, 16'h0001);
        rd_reg(acbw_pkg::ADDR_SP_SOURCE, 16'h0001);
        rd_reg(acbw_pkg::ADDR_MALFUNCTION, 16'h0006);
        repeat (20) @(posedge clk_i);
        check({31'h00000000, trip}, 32'h00000000);
    endtask
    task automatic t_codes();
        logic [15:0] rsv [3] = '{acbw_pkg::ADDR_RSVD_A, acbw_pkg::ADDR_RSVD_B,
                                 acbw_pkg::ADDR_RSVD_C};
        foreach (rsv[i])
        begin
            wr_reg(rsv[i], 16'h0001, 1'b1);
            rd_reg(rsv[i], 16'hFFFF);
        end
        for (int c = 0; c < 5; c++)
        begin
            wr_reg(acbw_pkg::ADDR_SENSOR_ONE, 16'(c), c == 2 || c == 3);
            rd_reg(acbw_pkg::ADDR_SENSOR_ONE, (c < 2) ? 16'(c) : 16'(c == 4 ? 4 : 1));
        end
        check({29'h00000000, sensor}, 32'h00000004);
        wr_reg(acbw_pkg::ADDR_SP_SOURCE, 16'h0000, 1'b0);
        wr_reg(acbw_pkg::ADDR_SENSOR_ONE, 16'h0001, 1'b0);
        repeat (2) @(posedge clk_i);
        check({30'h00000000, amv, src}, 32'h00000002);
        wr_reg(acbw_pkg::ADDR_SP_SOURCE, 16'h0001, 1'b0);
        wr_reg(acbw_pkg::ADDR_CTRL_MODE, 16'h0001, 1'b0);
        check({31'h00000000, mode}, 32'h00000001);
        wr_reg(acbw_pkg::ADDR_CTRL_MODE, 16'h0002, 1'b1);
        for (int u = 0; u < 8; u++)
        begin
            wr_reg(acbw_pkg::ADDR_FLOW_UNIT, 16'(u), u == 7);
            check({29'h00000000, unit}, (u == 7) ? 32'h00000006 : 32'(u));
        end
    endtask
    task automatic t_flow();
        wr_reg(acbw_pkg::ADDR_NOM_LOW, 16'h0000, 1'b1);
        wr_reg(acbw_pkg::ADDR_FLOW_UNIT, 16'h0001, 1'b0);
        repeat (2) @(posedge clk_i);
        rd_reg(acbw_pkg::ADDR_NOM_M3H, 16'h0064);
        rd_reg(acbw_pkg::ADDR_NOM_LOW, 16'h86A0);
        rd_reg(acbw_pkg::ADDR_NOM_HIGH, 16'h0001);
        wr_reg(acbw_pkg::ADDR_FLOW_UNIT, 16'h0004, 1'b0);
        repeat (2) @(posedge clk_i);
        rd_reg(acbw_pkg::ADDR_NOM_LOW, 16'hE100);
        rd_reg(acbw_pkg::ADDR_NOM_HIGH, 16'h05F5);
    endtask
    task automatic t_watchdog();
        int n;
        wr_reg(acbw_pkg::ADDR_FAIL_POS, 16'h0004, 1'b1);
        wr_reg(acbw_pkg::ADDR_FAIL_POS, 16'h0001, 1'b0);
        // Fail position output trails the stored field by one cycle
        @(posedge clk_i);
        check({30'h00000000, fpos}, 32'h00000001);
        rd_reg(acbw_pkg::ADDR_WD_TIMEOUT, 16'h0078);
        wr_reg(acbw_pkg::ADDR_WD_TIMEOUT, 16'h0E11, 1'b1);
        wr_reg(acbw_pkg::ADDR_WD_TIMEOUT, 16'h0001, 1'b0);
        pulse(1'b0);
        repeat (3) @(posedge clk_i);
        check({31'h00000000, trip}, 32'h00000000);
        n = 0;
        while (trip !== 1'b1 && n < 12)
        begin
            @(posedge clk_i);
            n++;
        end
        check({30'h00000000, trip, fact}, 32'h00000003);
        rd_reg(acbw_pkg::ADDR_MALFUNCTION, 16'h0406);
        pulse(1'b1);
        wr_reg(acbw_pkg::ADDR_WD_TIMEOUT, 16'h0000, 1'b0);
        check({31'h00000000, trip}, 32'h00000000);
        repeat (20) @(posedge clk_i);
        check({31'h00000000, trip}, 32'h00000000);
    endtask

    initial
    begin
        #20000;
        n_errors++;
        stop_test();
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_codes();
        t_flow();
        t_watchdog();
        stop_test();
    end
endmodule // tb_actuator_config_bus_watchdog
